// File: include/fetch_pipe_pkg.sv
// Shared constants and types for the quad-phase fetch pipeline
package fetch_pipe_pkg;

    // ************************************************************
    // Variants
    // ************************************************************
    localparam int VARIANT_SMALL  = 0;
    localparam int VARIANT_MIDDLE = 1;
    localparam int VARIANT_LARGE  = 2;

    // ************************************************************
    // Program memory geometry
    // ************************************************************
    localparam int PC_WIDTH_SMALL = 9;
    localparam int PC_WIDTH_LARGE = 11;
    localparam int PC_WIDTH_MAX   = 11;
    localparam int INSTR_WIDTH    = 12;
    localparam int PAGE_WORDS     = 512;
    localparam int PAGE_LOW_BITS  = 9;
    localparam logic [10:0] RESET_VECTOR_SMALL = 11'h1FF;
    localparam logic [10:0] RESET_VECTOR_LARGE = 11'h7FF;
    localparam logic [11:0] NO_OPERATION_WORD  = 12'h000;

    // ************************************************************
    // Register file sizing
    // ************************************************************
    localparam int BANK_LIMIT       = 32;
    localparam int SFR_COUNT_SMALL  = 7;
    localparam int GPR_COUNT_SMALL  = 25;
    localparam int SFR_COUNT_MIDDLE = 8;
    localparam int GPR_COUNT_MIDDLE = 8;
    localparam int GPR_BANKED_MIDDLE = 64;
    localparam int SFR_COUNT_LARGE  = 10;
    localparam int GPR_COUNT_LARGE  = 6;
    localparam int GPR_BANKED_LARGE = 128;

    // ************************************************************
    // Phase encoding and timing
    // ************************************************************
    localparam int PHASES_PER_CYCLE = 4;

    typedef enum logic [3:0] {
        PH_ONE   = 4'b0001,
        PH_TWO   = 4'b0010,
        PH_THREE = 4'b0100,
        PH_FOUR  = 4'b1000
    } phase_t;

    typedef struct packed {
        logic phase_one;
        logic phase_two;
        logic phase_three;
        logic phase_four;
    } phase_bus_t;

    typedef struct packed {
        logic       rd_strobe;
        logic       wr_strobe;
        logic       flush;
    } mem_ctrl_t;

endpackage : fetch_pipe_pkg

// File: hw/quad_phase_fetch_pipeline.sv
// Instruction-cycle sequencer and program-fetch pipeline
`timescale 1ns/10ps

module quad_phase_fetch_pipeline
    import fetch_pipe_pkg::*;
#(
    parameter int VARIANT = VARIANT_SMALL
)
(
    // Clock and reset
    input  wire logic                      core_clk_in,
    input  wire logic                      rst_n_in,
    // Oscillator mode
    input  wire logic                      resistor_capacitor_osc_mode_in,
    // Program memory
    output logic [PC_WIDTH_MAX-1:0]        program_addr_out,
    input  wire logic [INSTR_WIDTH-1:0]    program_data_in,
    // Execute-stage control from decode
    input  wire logic                      branch_taken_in,
    input  wire logic [PC_WIDTH_MAX-1:0]   branch_target_in,
    input  wire logic [1:0]                page_preselect_bits_in,
    input  wire logic [7:0]                file_select_pointer_in,
    input  wire logic [7:0]                file_addr_in,
    // Execute-stage outputs
    output logic [INSTR_WIDTH-1:0]         instr_reg_out,
    output logic                           instr_valid_out,
    output logic [7:0]                     data_addr_out,
    output mem_ctrl_t                      mem_ctrl_out,
    output phase_bus_t                     phases_out,
    output logic [PC_WIDTH_MAX-1:0]        program_counter_out,
    // Clock output pin
    output logic                           quarter_rate_clock_output_out,
    output logic                           quarter_rate_clock_output_oe_out,
    // Variant sizing
    output logic [7:0]                     sfr_count_out,
    output logic [7:0]                     gpr_unbanked_out,
    output logic [7:0]                     gpr_banked_out
);

    // ************************************************************
    // Variant configuration
    // ************************************************************
    // One value per variant; every sizing decision goes through here
    function automatic int by_variant(input int small_val,
                                      input int middle_val,
                                      input int large_val);
        case (VARIANT)
            VARIANT_SMALL:  by_variant = small_val;
            VARIANT_MIDDLE: by_variant = middle_val;
            default:        by_variant = large_val;
        endcase
    endfunction : by_variant

    localparam int          PC_W      = by_variant(PC_WIDTH_SMALL, PC_WIDTH_LARGE,
                                                   PC_WIDTH_LARGE);
    localparam logic [10:0] RESET_VEC = 11'(by_variant(int'(RESET_VECTOR_SMALL),
                                                       int'(RESET_VECTOR_LARGE),
                                                       int'(RESET_VECTOR_LARGE)));
    localparam int          SFR_N     = by_variant(SFR_COUNT_SMALL, SFR_COUNT_MIDDLE,
                                                   SFR_COUNT_LARGE);
    localparam int          GPR_N     = by_variant(GPR_COUNT_SMALL, GPR_COUNT_MIDDLE,
                                                   GPR_COUNT_LARGE);
    localparam int          GPR_B     = by_variant(0, GPR_BANKED_MIDDLE,
                                                   GPR_BANKED_LARGE);
    localparam bit          PAGED     = (PC_W > PAGE_LOW_BITS);
    localparam bit          BANKED    = ((SFR_N + GPR_N + GPR_B) > BANK_LIMIT);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // Only three variants have a geometry
    if (VARIANT < VARIANT_SMALL || VARIANT > VARIANT_LARGE)
    begin : g_bad_variant
        $error("VARIANT out of range");
    end
    // Counter must fit the address port
    if (PC_W > PC_WIDTH_MAX)
    begin : g_bad_width
        $error("Counter wider than address port");
    end
    // Start vector must lie inside implemented memory
    if ((int'(RESET_VEC) >> PC_W) != 0)
    begin : g_bad_vector
        $error("Reset vector outside implemented memory");
    end
    // Paging splices exactly two page bits above one page
    if (PAGED && (PC_W != PAGE_LOW_BITS + 2))
    begin : g_bad_paging
        $error("Paged counter must be page bits plus two");
    end
    // Page size and page offset bits must agree
    if (PAGE_WORDS != (1 << PAGE_LOW_BITS))
    begin : g_bad_page
        $error("Page size and page bits disagree");
    end
    // Sizing outputs are only eight bits wide
    if ((SFR_N + GPR_N + GPR_B) > 255)
    begin : g_bad_file
        $error("Register file too large for sizing outputs");
    end

    // ************************************************************
    // Phase generator
    // ************************************************************
    phase_t phase;
    phase_t next_phase;

    always_comb
    begin
        case (phase)
            PH_ONE:   next_phase = PH_TWO;
            PH_TWO:   next_phase = PH_THREE;
            PH_THREE: next_phase = PH_FOUR;
            PH_FOUR:  next_phase = PH_ONE;
            default:  next_phase = PH_ONE;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            phase <= PH_ONE;
        else
            phase <= next_phase;
    end

    wire is_one   = (phase == PH_ONE);
    wire is_two   = (phase == PH_TWO);
    wire is_three = (phase == PH_THREE);
    wire is_four  = (phase == PH_FOUR);

    assign phases_out = '{phase_one: is_one, phase_two: is_two,
                          phase_three: is_three, phase_four: is_four};

    // ************************************************************
    // Quarter-rate clock pin
    // ************************************************************
    logic clk_quarter;

    // Registered so the pin never glitches between phases
    wire next_quarter = (next_phase == PH_ONE) || (next_phase == PH_TWO);

    // high in phases one and two
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            clk_quarter <= 1'b0;
        else
            clk_quarter <= next_quarter;
    end

    assign quarter_rate_clock_output_out    = clk_quarter & resistor_capacitor_osc_mode_in;
    // Pin is crystal output otherwise
    assign quarter_rate_clock_output_oe_out = resistor_capacitor_osc_mode_in;

    // ************************************************************
    // Program counter
    // ************************************************************
    function automatic logic [PC_WIDTH_MAX-1:0] wrap_pc(input logic [PC_WIDTH_MAX-1:0] a);
        logic [PC_WIDTH_MAX-1:0] mask;
        mask = PC_WIDTH_MAX'((1 << PC_W) - 1);
        wrap_pc = a & mask;
    endfunction : wrap_pc

    logic [PC_WIDTH_MAX-1:0] pc;
    logic                    at_reset_vec;
    logic                    flush;

    // ************************************************************
    // Jump target
    // ************************************************************
    // page bits form the upper address
    wire [PC_WIDTH_MAX-1:0] paged_target = PAGED ?
        {page_preselect_bits_in, branch_target_in[PAGE_LOW_BITS-1:0]} : branch_target_in;

    wire [PC_WIDTH_MAX-1:0] jump_addr = wrap_pc(paged_target);

    wire jump_now = is_four && branch_taken_in && instr_valid_out;

    // ************************************************************
    // Counter step
    // ************************************************************
    // vector word is fetched before the first step
    wire step_now = is_one && !flush && !at_reset_vec;

    wire [PC_WIDTH_MAX-1:0] pc_plus_one = wrap_pc(pc + PC_WIDTH_MAX'(1));

    // reset vector increments and wraps to zero
    wire [PC_WIDTH_MAX-1:0] next_pc = step_now ? pc_plus_one :
                                      jump_now ? jump_addr : pc;

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            pc <= wrap_pc(RESET_VEC);
        else
            pc <= next_pc;
    end

    assign program_addr_out    = pc;
    assign program_counter_out = pc;

    // ************************************************************
    // Reset vector tracking
    // ************************************************************
    // cleared once the vector word is fetched
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            at_reset_vec <= 1'b1;
        else if (is_four)
            at_reset_vec <= 1'b0;
    end

    // ************************************************************
    // Fetch and execute stages
    // ************************************************************
    logic [INSTR_WIDTH-1:0] fetch_word;
    logic                   fetch_valid;

    wire branch_now = jump_now;

    // ************************************************************
    // Flush control
    // ************************************************************
    // Held through the bubble so its phase one skips the step

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            flush <= 1'b0;
        else if (branch_now)
            flush <= 1'b1;
        else if (is_four)
            flush <= 1'b0;
    end

    // ************************************************************
    // Fetch stage
    // ************************************************************
    // capture in phase four
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            fetch_word  <= NO_OPERATION_WORD;
            fetch_valid <= 1'b0;
        end
        else if (is_four)
        begin
            fetch_word  <= program_data_in;
            fetch_valid <= !branch_now;
        end
    end

    // ************************************************************
    // Execute stage
    // ************************************************************
    // Flushed slot becomes a bubble with no strobes
    wire [INSTR_WIDTH-1:0] next_instr = fetch_valid ? fetch_word : NO_OPERATION_WORD;

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            instr_reg_out   <= NO_OPERATION_WORD;
            instr_valid_out <= 1'b0;
        end
        else if (is_one)
        begin
            instr_reg_out   <= next_instr;
            instr_valid_out <= fetch_valid;
        end
    end

    // ************************************************************
    // Data memory address
    // ************************************************************
    // bank bits from pointer
    wire [2:0] bank_bits   = BANKED ? file_select_pointer_in[7:5] : 3'h0;
    wire [7:0] banked_addr = {bank_bits, file_addr_in[4:0]};

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            data_addr_out <= 8'h00;
        else if (is_one)
            data_addr_out <= banked_addr;
    end

    // ************************************************************
    // Strobe outputs
    // ************************************************************
    // read phase two, write phase four
    wire rd_now = is_two && instr_valid_out;
    wire wr_now = is_four && instr_valid_out;

    assign mem_ctrl_out = '{rd_strobe: rd_now,
                            wr_strobe: wr_now,
                            flush:     flush};

    // ************************************************************
    // Register file sizing
    // ************************************************************
    // sizing of the selected variant
    assign sfr_count_out    = 8'(SFR_N);
    assign gpr_unbanked_out = 8'(GPR_N);
    assign gpr_banked_out   = 8'(GPR_B);

endmodule : quad_phase_fetch_pipeline

// File: testbench/prog_mem_model.sv
// Program memory model for the fetch pipeline
`timescale 1ns/10ps
module prog_mem_model
    import fetch_pipe_pkg::*;
(
    input  wire logic [10:0] addr_in,
    output logic      [11:0] data_out
);
    // 12-bit words, top word of each 512-word page holds no-operation
    assign data_out = (addr_in[8:0] == 9'h1FF) ? NO_OPERATION_WORD
                                               : {addr_in[7:0] ^ 8'hA5, addr_in[10:7]};
endmodule : prog_mem_model

// File: testbench/quad_phase_fetch_pipeline_chk.sv
// Assertion checker for the fetch pipeline
`timescale 1ns/10ps
module quad_phase_fetch_pipeline_chk
    import fetch_pipe_pkg::*;
#(
    parameter int VARIANT = VARIANT_SMALL
)
(
    input wire logic        core_clk_in,
    input wire logic        rst_n_in,
    input wire logic        resistor_capacitor_osc_mode_in,
    input wire logic [10:0] program_addr_out,
    input wire logic        branch_taken_in,
    input wire logic [10:0] branch_target_in,
    input wire logic [1:0]  page_preselect_bits_in,
    input wire logic [11:0] instr_reg_out,
    input wire logic        instr_valid_out,
    input wire mem_ctrl_t   mem_ctrl_out,
    input wire phase_bus_t  phases_out,
    input wire logic [10:0] program_counter_out,
    input wire logic        quarter_rate_clock_output_out,
    input wire logic        quarter_rate_clock_output_oe_out,
    input wire logic [7:0]  sfr_count_out,
    input wire logic [7:0]  gpr_unbanked_out,
    input wire logic [7:0]  gpr_banked_out,
    input wire logic [7:0]  file_select_pointer_in,
    input wire logic [7:0]  file_addr_in,
    input wire logic [7:0]  data_addr_out
);
    localparam logic [7:0]  GPRS = (VARIANT == VARIANT_SMALL) ? 8'h19
                                 : (VARIANT == VARIANT_MIDDLE) ? 8'h08 : 8'h06;
    localparam logic [7:0]  BNKS = (VARIANT == VARIANT_SMALL) ? 8'h00
                                 : (VARIANT == VARIANT_MIDDLE) ? 8'h40 : 8'h80;
    localparam logic [10:0] MASK = (VARIANT == VARIANT_SMALL) ? 11'h1FF : 11'h7FF;
    localparam logic [7:0]  SFRS = (VARIANT == VARIANT_SMALL) ? 8'h07
                                 : (VARIANT == VARIANT_MIDDLE) ? 8'h08 : 8'h0A;
    wire take = phases_out.phase_four && branch_taken_in && instr_valid_out;
    function automatic logic [10:0] jump_to(logic [10:0] t, logic [1:0] p);
        return (VARIANT == VARIANT_SMALL) ? (t & MASK) : {p, t[8:0]};
    endfunction : jump_to
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_rotate;
        phases_out.phase_two ##1 phases_out.phase_three ##1 phases_out.phase_four
            ##1 phases_out.phase_one;
    endsequence
    property p_phase_rot; phases_out.phase_one |=> s_rotate; endproperty
    a_phase_rot: assert property (p_phase_rot) else $error("phase order broken");
    property p_onehot; $onehot(phases_out); endproperty
    a_onehot: assert property (p_onehot) else $error("phases overlap");
    property p_pc_hold; phases_out.phase_two |=> $stable(program_counter_out) [*2]; endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("counter moved mid cycle");
    property p_pc_step;
        phases_out.phase_four && !take
            |-> ##2 program_counter_out == (($past(program_counter_out, 2) + 11'h001) & MASK);
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("counter step wrong");
    property p_branch;
        take |=> (program_counter_out == jump_to($past(branch_target_in),
            $past(page_preselect_bits_in)) && mem_ctrl_out.flush)
            ##1 ($stable(program_counter_out) && !instr_valid_out);
    endproperty
    a_branch: assert property (p_branch) else $error("branch handling wrong");
    property p_rd; mem_ctrl_out.rd_strobe == (phases_out.phase_two && instr_valid_out); endproperty
    a_rd: assert property (p_rd) else $error("read strobe wrong");
    property p_wr; mem_ctrl_out.wr_strobe == (phases_out.phase_four && instr_valid_out); endproperty
    a_wr: assert property (p_wr) else $error("write strobe wrong");
    property p_ir_hold; !$stable(instr_reg_out) |-> $past(phases_out.phase_one); endproperty
    a_ir_hold: assert property (p_ir_hold) else $error("instruction changed off phase");
    property p_qclk;
        quarter_rate_clock_output_out == (resistor_capacitor_osc_mode_in
            && (phases_out.phase_one || phases_out.phase_two))
            && quarter_rate_clock_output_oe_out == resistor_capacitor_osc_mode_in;
    endproperty
    a_qclk: assert property (p_qclk) else $error("quarter clock wrong");
    property p_addr;
        program_addr_out == program_counter_out && (program_counter_out & ~MASK) == 11'h000;
    endproperty
    a_addr: assert property (p_addr) else $error("address width wrong");
    property p_size; sfr_count_out == SFRS; endproperty
    a_size: assert property (p_size) else $error("register count wrong");
    property p_gpr; gpr_unbanked_out == GPRS && gpr_banked_out == BNKS; endproperty
    a_gpr: assert property (p_gpr) else $error("general count wrong");
    property p_bank;
        phases_out.phase_two |-> data_addr_out == {((VARIANT == VARIANT_SMALL) ? 3'h0
            : $past(file_select_pointer_in[7:5])), $past(file_addr_in[4:0])};
    endproperty
    a_bank: assert property (p_bank) else $error("data address wrong");
endmodule : quad_phase_fetch_pipeline_chk
bind quad_phase_fetch_pipeline quad_phase_fetch_pipeline_chk #(.VARIANT(VARIANT)) i_chk (.*);

// File: testbench/test_quad_phase_fetch_pipeline.sv
// Self-checking bench for the fetch pipeline
`timescale 1ns/10ps
module test_quad_phase_fetch_pipeline;
    import fetch_pipe_pkg::*;
    logic clk, rst_n, rc, br, exp_v, is_ph3, is_ph4;
    logic [10:0] tgt, pa, pc, exp_pc;
    logic [1:0] pg;
    logic [7:0] fsp, fad;
    logic [11:0] pdata, ir, exp_ir;
    logic v;
    int n_mismatch, n_checks;
    quad_phase_fetch_pipeline #(.VARIANT(VARIANT_SMALL)) i_dut (
        .core_clk_in(clk), .rst_n_in(rst_n), .resistor_capacitor_osc_mode_in(rc),
        .program_addr_out(pa), .program_data_in(pdata), .branch_taken_in(br),
        .branch_target_in(tgt), .page_preselect_bits_in(pg), .file_select_pointer_in(fsp),
        .file_addr_in(fad), .instr_reg_out(ir), .instr_valid_out(v), .data_addr_out(),
        .mem_ctrl_out(), .phases_out(), .program_counter_out(pc),
        .quarter_rate_clock_output_out(), .quarter_rate_clock_output_oe_out(),
        .sfr_count_out(), .gpr_unbanked_out(), .gpr_banked_out());
    prog_mem_model i_mem (.addr_in(pa), .data_out(pdata));
    task chk(string what, logic [11:0] e, logic [11:0] s);
        n_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask : chk
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    // Generous bound; the run needs about 2000 clocks
    initial
    begin
        repeat (10000) @(posedge clk);
        n_mismatch++;
        close_out;
    end
    initial
    begin
        {rst_n, rc, br, tgt, pg, fsp, fad} = '0;
        n_mismatch = 0;
        n_checks = 0;
        void'($urandom(32'hcc3d));
        repeat (12) @(posedge clk);
        @(negedge clk);
        chk("reset pc", 12'h1FF, {1'b0, pc});
        @(posedge clk);
        rst_n <= 1'b1;
        exp_pc = 11'h1FF;
        exp_v = 1'b0;
        for (int k = 0; k < 2000; k++)
        begin
            @(negedge clk);
            is_ph3 = i_dut.phases_out.phase_three;
            is_ph4 = i_dut.phases_out.phase_four;
            if (i_dut.phases_out.phase_two)
            begin
                chk("pc", {1'b0, exp_pc}, {1'b0, pc});
                chk("valid", {11'h000, exp_v}, {11'h000, v});
                if (exp_v)
                    chk("instr", exp_ir, ir);
            end
            if (is_ph4)
            begin
                chk("addr", {1'b0, exp_pc}, {1'b0, pa});
                exp_ir = pdata;
                exp_v = !(br && exp_v);
                exp_pc = exp_v ? ((exp_pc + 11'h001) & 11'h1FF) : (tgt & 11'h1FF);
            end
            @(posedge clk);
            fsp <= 8'($urandom);
            fad <= 8'($urandom);
            pg <= 2'($urandom);
            // Early cycles branch every time: wrap at the top and refusal in the bubble
            if (is_ph3)
            begin
                br <= (k < 200) ? 1'b1 : ($urandom_range(3) == 0);
                tgt <= (k < 200) ? 11'h7FF : 11'($urandom);
            end
            if (is_ph4)
            begin
                br <= 1'b0;
                rc <= 1'($urandom);
            end
        end
        close_out;
    end
endmodule : test_quad_phase_fetch_pipeline
